// >>> i2c_master_sequencer.sv
// Master sequencer for a two-wire serial port: start, restart, stop,
// byte transmit with acknowledge capture, byte receive, clock arbitration.
// Assumes open-drain pads outside; scl_in/sda_in are raw pad levels.
// Behaviour
// R1 - Released SCL freezes counter until seen high
// R2 - SCL seen high reloads counter from divisor
// R3 - Busy buffer write sets collision, keeps buffer
// R4 - Control writes ignored while start pending
// R5 - Start: both high, count, then SDA low
// R6 - After SDA low, count, clear start request
// R7 - Lines low or SCL low aborts start
// R8 - Restart: pull SCL low, count SDA high
// R9 - Restart release, both high, SDA low, finish
// R10 - Start seen at once; restart flag later
// R11 - Restart request ignored while busy
// R12 - Restart collision: SDA low or SCL early
// R13 - Idle buffer write sets full, starts transmit
// R14 - Bit after SCL falls; low and high periods
// R15 - Eighth falling edge clears full, frees SDA
// R16 - Ninth clock SDA becomes acknowledge status
// R17 - After ninth clock flag, hold SCL low
// R18 - Address: seven bits then direction bit
// R19 - Software clears write collision before sending
// R20 - Software waits start flag; ends via stop
// R21 - Reception only on receive request bit
// R22 - Eighth received edge loads buffer, flags, holds
// R23 - Lines open drain, sampled synchronously first
`timescale 1ns/1ps
module i2c_master_sequencer (
   input  wire logic                        clk,
   input  wire logic                        nrst,
   input  wire logic                        ce,
   input  wire logic                        scl_in,
   output logic                             scl_out,
   output logic                             scl_oe,
   input  wire logic                        sda_in,
   output logic                             sda_out,
   output logic                             sda_oe,
   input  wire logic [7:0]                  baud_divisor,
   input  wire logic                        buffer_write,
   input  wire logic [7:0]                  buffer_wdata,
   input  wire logic                        buffer_read,
   input  wire logic                        control_write,
   input  wire i2c_seq_pkg::control_two_t   control_wdata,
   input  wire logic                        collision_clear,
   input  wire logic                        interrupt_clear,
   input  wire logic                        bus_collision_clear,
   output logic [7:0]                       shift_buffer,
   output logic                             buffer_full_flag,
   output logic                             write_collision_flag,
   output logic                             ack_status,
   output logic                             port_interrupt_flag,
   output logic                             collision_interrupt_flag,
   output logic                             start_seen,
   output i2c_seq_pkg::control_two_t        control_two
);

   i2c_seq_pkg::seq_regs_t s;
   i2c_seq_pkg::seq_regs_t next_s;

   logic tick;
   logic busy;

   localparam logic [3:0] ACK_SLOT_L = i2c_seq_pkg::ACK_SLOT;
   localparam logic [3:0] BITS_L     = i2c_seq_pkg::BITS_PER_BYTE;

   assign tick = (s.rate_counter == i2c_seq_pkg::COUNT_RESET);
   assign busy = (s.st != i2c_seq_pkg::IDLE) || (s.control_two != i2c_seq_pkg::CONTROL_RESET);

   always_comb begin
      next_s = s;
      // Pads only ever pull low [R23]
      next_s.scl_meta = scl_in;
      next_s.scl_sync = s.scl_meta;
      next_s.scl_prev = s.scl_sync;
      next_s.sda_meta = sda_in;
      next_s.sda_sync = s.sda_meta;
      next_s.sda_prev = s.sda_sync;
      // Line-level start detection, independent of the sequencer [R10]
      if (s.sda_prev && !s.sda_sync && s.scl_sync) begin
         next_s.start_seen = 1'b1;
      end else if (!s.sda_prev && s.sda_sync && s.scl_sync) begin
         next_s.start_seen = 1'b0;
      end
      // Software clears first so that hardware sets below win
      if (collision_clear) begin
         next_s.write_collision_flag = 1'b0;
      end
      if (interrupt_clear) begin
         next_s.port_interrupt_flag = 1'b0;
      end
      if (bus_collision_clear) begin
         next_s.collision_interrupt_flag = 1'b0;
      end
      if (buffer_read) begin
         next_s.buffer_full_flag = 1'b0;
      end
      // No queuing while a start is pending [R4]
      if (control_write && !s.control_two.start_request) begin
         next_s.control_two = control_wdata;
         // A restart written during any other activity has no effect [R11]
         if (s.st != i2c_seq_pkg::IDLE) begin
            next_s.control_two.restart_request = s.control_two.restart_request;
         end
      end
      // Counting states decrement to zero and stop there; only some states reload on timeout
      if (!tick) begin
         next_s.rate_counter = s.rate_counter - 8'h01;
      end
      unique case (s.st)
         i2c_seq_pkg::IDLE: begin
            next_s.rate_counter = s.rate_counter;
            if (s.control_two.start_request) begin
               if (s.sda_sync && s.scl_sync) begin
                  next_s.rate_counter = baud_divisor; // [R5]
                  next_s.st = i2c_seq_pkg::ST_WAIT;
               end else if (!s.sda_sync && !s.scl_sync) begin
                  next_s.collision_interrupt_flag = 1'b1; // [R7]
                  next_s.control_two.start_request = 1'b0;
               end
            end else if (s.control_two.restart_request) begin
               next_s.scl_oe = 1'b1; // [R8]
               next_s.st = i2c_seq_pkg::RS_LOW;
            end else if (s.control_two.stop_request) begin
               next_s.scl_oe = 1'b1;
               next_s.sda_oe = 1'b1;
               next_s.rate_counter = baud_divisor;
               next_s.st = i2c_seq_pkg::SP_LO;
            end else if (s.control_two.receive_request) begin
               next_s.scl_oe = 1'b1; // [R21]
               next_s.sda_oe = 1'b0;
               next_s.bit_count = 4'h0;
               next_s.rate_counter = baud_divisor;
               next_s.st = i2c_seq_pkg::RX_LO;
            end
         end
         i2c_seq_pkg::ST_WAIT: begin
            if (!s.scl_sync) begin
               next_s.collision_interrupt_flag = 1'b1; // [R7]
               next_s.control_two.start_request = 1'b0;
               next_s.st = i2c_seq_pkg::IDLE;
            end else if (tick && s.sda_sync) begin
               next_s.sda_oe = 1'b1; // [R5]
               next_s.rate_counter = baud_divisor; // [R6]
               next_s.st = i2c_seq_pkg::ST_HOLD;
            end else if (tick) begin
               next_s.collision_interrupt_flag = 1'b1;
               next_s.control_two.start_request = 1'b0;
               next_s.st = i2c_seq_pkg::IDLE;
            end
         end
         i2c_seq_pkg::ST_HOLD: begin
            if (tick) begin
               next_s.control_two.start_request = 1'b0; // [R6]
               next_s.port_interrupt_flag = 1'b1;
               next_s.st = i2c_seq_pkg::IDLE;
            end
         end
         i2c_seq_pkg::RS_LOW: begin
            next_s.rate_counter = s.rate_counter;
            if (!s.scl_sync) begin
               next_s.sda_oe = 1'b0; // [R8]
               next_s.rate_counter = baud_divisor;
               next_s.st = i2c_seq_pkg::RS_SDAHI;
            end
         end
         i2c_seq_pkg::RS_SDAHI: begin
            if (tick) begin
               next_s.rate_counter = s.rate_counter;
               // SCL is let go only once SDA is really high [R9]
               if (s.sda_sync) begin
                  next_s.scl_oe = 1'b0;
                  next_s.st = i2c_seq_pkg::RS_WAITHI;
               end
            end
         end
         i2c_seq_pkg::RS_WAITHI: begin
            next_s.rate_counter = s.rate_counter; // [R1]
            if (s.scl_sync) begin
               if (!s.sda_sync) begin
                  next_s.collision_interrupt_flag = 1'b1; // [R12]
                  next_s.control_two.restart_request = 1'b0;
                  next_s.st = i2c_seq_pkg::IDLE;
               end else begin
                  next_s.rate_counter = baud_divisor; // [R2]
                  next_s.st = i2c_seq_pkg::RS_BOTHHI;
               end
            end
         end
         i2c_seq_pkg::RS_BOTHHI: begin
            if (!s.scl_sync) begin
               next_s.collision_interrupt_flag = 1'b1; // [R12]
               next_s.control_two.restart_request = 1'b0;
               next_s.st = i2c_seq_pkg::IDLE;
            end else if (tick) begin
               next_s.sda_oe = 1'b1; // [R9]
               next_s.rate_counter = baud_divisor;
               next_s.st = i2c_seq_pkg::RS_SDALO;
            end
         end
         i2c_seq_pkg::RS_SDALO: begin
            if (tick) begin
               // No reload here; the counter rests at zero [R9]
               next_s.rate_counter = s.rate_counter;
               next_s.scl_oe = 1'b1;
               next_s.control_two.restart_request = 1'b0;
               next_s.port_interrupt_flag = 1'b1; // [R10]
               next_s.st = i2c_seq_pkg::IDLE;
            end
         end
         i2c_seq_pkg::TX_LO: begin
            next_s.scl_oe = 1'b1;
            // Data changes only while SCL is low [R14] [R18]
            next_s.sda_oe = (s.bit_count == ACK_SLOT_L) ? 1'b0 : ~s.shift_register[7];
            if (tick) begin
               next_s.scl_oe = 1'b0;
               next_s.st = i2c_seq_pkg::TX_WAITHI;
            end
         end
         i2c_seq_pkg::TX_WAITHI: begin
            next_s.rate_counter = s.rate_counter; // [R1]
            if (s.scl_sync) begin
               next_s.rate_counter = baud_divisor; // [R2]
               next_s.st = i2c_seq_pkg::TX_HI;
            end
         end
         i2c_seq_pkg::TX_HI: begin
            if (tick) begin
               next_s.scl_oe = 1'b1; // [R14]
               next_s.rate_counter = baud_divisor;
               if (s.bit_count == ACK_SLOT_L) begin
                  next_s.ack_status = s.sda_sync; // [R16]
                  next_s.port_interrupt_flag = 1'b1; // [R17]
                  next_s.sda_oe = 1'b0;
                  next_s.rate_counter = s.rate_counter;
                  next_s.st = i2c_seq_pkg::IDLE;
               end else begin
                  next_s.shift_register = {s.shift_register[6:0], 1'b0};
                  next_s.bit_count = s.bit_count + 4'h1;
                  next_s.st = i2c_seq_pkg::TX_LO;
                  if (s.bit_count == BITS_L - 4'h1) begin
                     next_s.buffer_full_flag = 1'b0; // [R15]
                     next_s.sda_oe = 1'b0;
                  end
               end
            end
         end
         i2c_seq_pkg::RX_LO: begin
            if (tick) begin
               next_s.scl_oe = 1'b0;
               next_s.st = i2c_seq_pkg::RX_WAITHI;
            end
         end
         i2c_seq_pkg::RX_WAITHI: begin
            next_s.rate_counter = s.rate_counter; // [R1]
            if (s.scl_sync) begin
               next_s.rate_counter = baud_divisor; // [R2]
               next_s.st = i2c_seq_pkg::RX_HI;
            end
         end
         i2c_seq_pkg::RX_HI: begin
            if (tick) begin
               next_s.scl_oe = 1'b1;
               next_s.shift_register = {s.shift_register[6:0], s.sda_sync};
               next_s.bit_count = s.bit_count + 4'h1;
               next_s.rate_counter = baud_divisor;
               next_s.st = i2c_seq_pkg::RX_LO;
               if (s.bit_count == BITS_L - 4'h1) begin
                  // Byte lands in the buffer, clock held low [R22]
                  next_s.shift_buffer = {s.shift_register[6:0], s.sda_sync};
                  next_s.buffer_full_flag = 1'b1;
                  next_s.port_interrupt_flag = 1'b1;
                  next_s.control_two.receive_request = 1'b0;
                  next_s.rate_counter = s.rate_counter;
                  next_s.st = i2c_seq_pkg::IDLE;
               end
            end
         end
         i2c_seq_pkg::SP_LO: begin
            if (tick) begin
               next_s.scl_oe = 1'b0;
               next_s.st = i2c_seq_pkg::SP_WAITHI;
            end
         end
         i2c_seq_pkg::SP_WAITHI: begin
            next_s.rate_counter = s.rate_counter; // [R1]
            if (s.scl_sync) begin
               next_s.rate_counter = baud_divisor; // [R2]
               next_s.st = i2c_seq_pkg::SP_HI;
            end
         end
         i2c_seq_pkg::SP_HI: begin
            if (tick) begin
               next_s.sda_oe = 1'b0;
               next_s.rate_counter = baud_divisor;
               next_s.st = i2c_seq_pkg::SP_END;
            end
         end
         i2c_seq_pkg::SP_END: begin
            if (tick) begin
               next_s.control_two.stop_request = 1'b0;
               next_s.port_interrupt_flag = 1'b1;
               next_s.st = i2c_seq_pkg::IDLE;
            end
         end
      endcase
      // After the case, so the idle counter freeze cannot undo the load
      if (buffer_write) begin
         if (busy) begin
            next_s.write_collision_flag = 1'b1; // [R3]
         end else begin
            next_s.shift_buffer = buffer_wdata;
            next_s.shift_register = buffer_wdata;
            next_s.buffer_full_flag = 1'b1; // [R13]
            next_s.bit_count = 4'h0;
            next_s.rate_counter = baud_divisor;
            next_s.st = i2c_seq_pkg::TX_LO;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
         s.scl_meta <= 1'b1;
         s.scl_sync <= 1'b1;
         s.scl_prev <= 1'b1;
         s.sda_meta <= 1'b1;
         s.sda_sync <= 1'b1;
         s.sda_prev <= 1'b1;
         s.shift_buffer <= i2c_seq_pkg::BUFFER_RESET;
         s.control_two <= i2c_seq_pkg::CONTROL_RESET;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // Level driven is always low; only the enables move [R23]
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = s.scl_oe;
   assign sda_oe = s.sda_oe;
   assign shift_buffer = s.shift_buffer;
   assign buffer_full_flag = s.buffer_full_flag;
   assign write_collision_flag = s.write_collision_flag;
   assign ack_status = s.ack_status;
   assign port_interrupt_flag = s.port_interrupt_flag;
   assign collision_interrupt_flag = s.collision_interrupt_flag;
   assign start_seen = s.start_seen;
   assign control_two = s.control_two;

   default clocking dc @(posedge clk); endclocking
   default disable iff (!nrst);

   chk_write_collision_flag_keeps_buf: assert property (ce && buffer_write && busy && !(s.st == i2c_seq_pkg::RX_HI && tick) |=> // [R3]
      s.write_collision_flag && $stable(s.shift_buffer)) else $error("busy write changed buffer");
   chk_start_sda_low: assert property (ce && s.st == i2c_seq_pkg::ST_WAIT && tick && // [R5]
      s.scl_sync && s.sda_sync |=> s.sda_oe && s.rate_counter == $past(baud_divisor))
      else $error("start did not pull SDA low");
   chk_start_abort_low: assert property (ce && s.st == i2c_seq_pkg::IDLE && // [R7]
      s.control_two.start_request && !s.sda_sync && !s.scl_sync |=>
      s.collision_interrupt_flag && !s.control_two.start_request && s.st == i2c_seq_pkg::IDLE)
      else $error("start on low lines not aborted");
   chk_arb_freeze: assert property (ce && s.st == i2c_seq_pkg::TX_WAITHI && !s.scl_sync |=> // [R1]
      s.st == i2c_seq_pkg::TX_WAITHI && $stable(s.rate_counter)) else $error("counter ran while SCL low");
   chk_arb_reload: assert property (ce && s.st == i2c_seq_pkg::RX_WAITHI && s.scl_sync |=> // [R2]
      s.st == i2c_seq_pkg::RX_HI && s.rate_counter == $past(baud_divisor)) else $error("no reload on SCL high");
   chk_eighth_frees: assert property (ce && s.st == i2c_seq_pkg::TX_HI && tick && // [R15]
      s.bit_count == 4'h7 |=> !s.buffer_full_flag && !s.sda_oe && s.scl_oe) else $error("eighth edge wrong");
   chk_ack_capture: assert property (ce && s.st == i2c_seq_pkg::TX_HI && tick && // [R16]
      s.bit_count == 4'h8 |=> s.ack_status == $past(s.sda_sync) && s.port_interrupt_flag &&
      s.scl_oe && !s.sda_oe && s.st == i2c_seq_pkg::IDLE) else $error("ack not captured");
   chk_start_locked: assert property (ce && control_write && s.control_two.start_request |=> // [R4]
      s.control_two[3:1] == $past(s.control_two[3:1])) else $error("control written during start");
   chk_rx_loads: assert property (ce && s.st == i2c_seq_pkg::RX_HI && tick && // [R22]
      s.bit_count == 4'h7 |=> s.buffer_full_flag && s.port_interrupt_flag &&
      !s.control_two.receive_request && s.scl_oe) else $error("received byte not delivered");

   cov_start_done: cover property (s.st == i2c_seq_pkg::ST_HOLD ##1 s.st == i2c_seq_pkg::IDLE);
   cov_restart_done: cover property (s.st == i2c_seq_pkg::RS_SDALO ##1 s.st == i2c_seq_pkg::IDLE);
   cov_tx_ack: cover property (s.st == i2c_seq_pkg::TX_HI && tick && s.bit_count == 4'h8);
   cov_rx_byte: cover property (s.st == i2c_seq_pkg::RX_HI && tick && s.bit_count == 4'h7);

endmodule

// >>> i2c_seq_pkg.sv
// Shared types and constants for the two-wire master sequencer.
// Assumes a single system clock; bus lines arrive unsynchronised.
package i2c_seq_pkg;

   // Request bits of the second control register, high bit first
   typedef struct packed {
      logic receive_request;
      logic stop_request;
      logic restart_request;
      logic start_request;
   } control_two_t;

   typedef enum logic [4:0] {
      IDLE,
      ST_WAIT, ST_HOLD,
      RS_LOW, RS_SDAHI, RS_WAITHI, RS_BOTHHI, RS_SDALO,
      TX_LO, TX_WAITHI, TX_HI,
      RX_LO, RX_WAITHI, RX_HI,
      SP_LO, SP_WAITHI, SP_HI, SP_END
   } seq_state_t;

   typedef struct packed {
      seq_state_t   st;
      logic [7:0]   rate_counter;
      logic [3:0]   bit_count;
      logic [7:0]   shift_register;
      logic [7:0]   shift_buffer;
      logic         buffer_full_flag;
      logic         write_collision_flag;
      logic         ack_status;
      logic         port_interrupt_flag;
      logic         collision_interrupt_flag;
      logic         start_seen;
      control_two_t control_two;
      logic         scl_oe;
      logic         sda_oe;
      logic         scl_meta;
      logic         scl_sync;
      logic         scl_prev;
      logic         sda_meta;
      logic         sda_sync;
      logic         sda_prev;
   } seq_regs_t;

   localparam logic [7:0]   COUNT_RESET   = 8'h00;
   localparam logic [3:0]   BITS_PER_BYTE = 4'h8;
   localparam logic [3:0]   ACK_SLOT      = 4'h8;
   localparam logic [7:0]   BUFFER_RESET  = 8'h00;
   localparam control_two_t CONTROL_RESET = 4'h0;

endpackage

// >>> i2c_slave_model.sv
// Behavioural two-wire slave: acknowledges writes, serves a read byte.
// Assumes pulled-up wires; drives only open-drain enables.
`timescale 1ns/1ps
module i2c_slave_model (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       ack_en,
   input  wire logic       rd,
   input  wire logic       stretch,
   input  wire logic [7:0] tx_byte,
   output logic            scl_oe,
   output logic            sda_oe,
   output logic [7:0]      rx_byte
);
   int bit_n = 0;
   initial begin
      scl_oe = 0;
      sda_oe = 0;
      rx_byte = 8'h00;
   end
   always @(negedge sda) if (scl) bit_n = 0;
   always @(posedge scl) begin
      if (bit_n < 8) rx_byte = {rx_byte[6:0], sda};
      bit_n++;
   end
   // Released line floats high through the pull-up
   always @(negedge scl or posedge rd) begin
      if (bit_n == 9) bit_n = 0;
      if (bit_n == 8) sda_oe = ~rd & ack_en;
      else if (bit_n < 8) sda_oe = rd & ~tx_byte[7 - bit_n];
      else sda_oe = 0;
   end
   // Slow slave: holds SCL low after each fall
   always @(negedge scl) if (stretch) begin
      scl_oe = 1;
      #1000;
      scl_oe = 0;
   end
endmodule

// >>> tb_top.sv
// Self-checking bench for the two-wire master sequencer.
// Assumes the slave model on pulled-up wires; inputs change at falling clk.
`timescale 1ns/1ps
module tb_top;
   logic       clk = 0, nrst = 0, ce = 1;
   logic       buffer_write = 0, buffer_read = 0, control_write = 0;
   logic       collision_clear = 0, interrupt_clear = 0, bus_collision_clear = 0;
   logic [7:0] baud_divisor = 8'h03, buffer_wdata = 8'h00, tx_byte = 8'h3c;
   logic [7:0] shift_buffer, rx_byte;
   logic       scl_out, scl_oe, sda_out, sda_oe, s_scl_oe, s_sda_oe, t_scl_oe = 0, t_sda_oe = 0;
   logic       buffer_full_flag, write_collision_flag, ack_status, port_interrupt_flag;
   logic       collision_interrupt_flag, start_seen, ack_en = 1, rd = 0, stretch = 0;
   int         err_total = 0, tests_run = 0;
   i2c_seq_pkg::control_two_t control_wdata = 4'h0, control_two;
   wire        scl = ~(scl_oe | s_scl_oe | t_scl_oe);
   wire        sda = ~(sda_oe | s_sda_oe | t_sda_oe);
   always #20 clk = ~clk;
   i2c_master_sequencer DUT (.clk, .nrst, .ce, .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out,
      .sda_oe, .baud_divisor, .buffer_write, .buffer_wdata, .buffer_read, .control_write, .control_wdata,
      .collision_clear, .interrupt_clear, .bus_collision_clear, .shift_buffer, .buffer_full_flag,
      .write_collision_flag, .ack_status, .port_interrupt_flag, .collision_interrupt_flag, .start_seen,
      .control_two);
   i2c_slave_model slv (.scl, .sda, .ack_en, .rd, .stretch, .tx_byte, .scl_oe(s_scl_oe), .sda_oe(s_sda_oe),
      .rx_byte);
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wait_flag(input bit coll);
      int n = 0;
      while ((coll ? collision_interrupt_flag : port_interrupt_flag) !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > 4000) begin
            chk(12'h000, 12'h001, "flag wait timed out");
            summarize();
         end
      end
   endtask
   task automatic cw(input i2c_seq_pkg::control_two_t v);
      @(negedge clk);
      control_wdata = v;
      control_write = 1;
      @(negedge clk);
      control_write = 0;
   endtask
   task automatic bw(input logic [7:0] d);
      @(negedge clk);
      buffer_wdata = d;
      buffer_write = 1;
      @(negedge clk);
      buffer_write = 0;
   endtask
   task automatic clr();
      @(negedge clk);
      {interrupt_clear, collision_clear, bus_collision_clear} = 3'h7;
      @(negedge clk);
      {interrupt_clear, collision_clear, bus_collision_clear} = 3'h0;
   endtask
   task automatic t_start();
      cw(4'h1);
      cw(4'h2);
      chk(control_two, 4'h1, "request taken during start");
      bw(8'h77);
      chk({write_collision_flag, shift_buffer}, 12'h100, "early buffer write");
      wait_flag(0);
      chk({start_seen, sda_oe, scl_oe, control_two}, 12'h060, "start end");
      chk({scl_out, sda_out}, 12'h000, "pad level not low");
      clr();
      $display("start test done");
   endtask
   task automatic t_tx(input logic [7:0] d, input logic a, input logic s);
      ack_en = a;
      stretch = s;
      bw(d);
      chk(buffer_full_flag, 1, "full flag after write");
      cw(4'h2);
      chk(control_two, 4'h0, "restart taken while busy");
      bw(8'h11);
      chk({write_collision_flag, shift_buffer}, {4'h1, d}, "buffer write while busy");
      wait_flag(0);
      chk({buffer_full_flag, ack_status, sda_oe, scl_oe}, {1'b0, ~a, 2'b01}, "byte end");
      chk(rx_byte, d, "byte seen by slave");
      clr();
      stretch = 0;
      $display("transmit test done");
   endtask
   task automatic t_rx();
      rd = 1;
      cw(4'h8);
      wait_flag(0);
      chk({3'h0, buffer_full_flag, shift_buffer}, {4'h1, tx_byte}, "byte received");
      chk(control_two, 4'h0, "receive request not cleared");
      chk(scl_oe, 1, "clock not held");
      // Clock enable low must freeze the full flag against a read
      ce = 0;
      @(negedge clk);
      buffer_read = 1;
      @(negedge clk);
      buffer_read = 0;
      chk(buffer_full_flag, 1, "state moved with ce low");
      ce = 1;
      @(negedge clk);
      buffer_read = 1;
      @(negedge clk);
      buffer_read = 0;
      chk(buffer_full_flag, 0, "full flag after read");
      rd = 0;
      clr();
      $display("receive test done");
   endtask
   task automatic t_ctl(input i2c_seq_pkg::control_two_t v, input logic [2:0] lines);
      cw(v);
      wait_flag(0);
      chk({start_seen, sda_oe, scl_oe, control_two}, {lines, 4'h0}, "restart or stop end");
      clr();
      $display("restart/stop test done");
   endtask
   // Bench stands in for a rival master pulling the lines
   task automatic t_coll(input logic early);
      t_scl_oe = early;
      t_sda_oe = early;
      repeat (4) @(negedge clk);
      cw(4'h1);
      t_scl_oe = 1;
      wait_flag(1);
      chk({control_two, sda_oe, scl_oe}, 12'h000, "start not aborted");
      t_scl_oe = 0;
      t_sda_oe = 0;
      clr();
      $display("collision test done");
   endtask
   initial begin
      repeat (5) @(negedge clk);
      nrst = 1;
      repeat (3) @(negedge clk);
      t_start();
      t_tx(8'ha4, 1, 0);
      t_tx(8'h5b, 0, 1);
      t_rx();
      t_ctl(4'h2, 3'h7);
      t_ctl(4'h4, 3'h0);
      t_coll(1);
      t_coll(0);
      summarize();
   end
endmodule
